// file: rtl/adc_cal_pkg.sv
package adc_cal_pkg;
   // ------------------------------------------------------------
   // Register map (serial port register addresses, byte-wide port)
   // ------------------------------------------------------------
   localparam logic [2:0] ADDR_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_OFFSET = 3'h1;
   localparam logic [2:0] ADDR_POSFS = 3'h2;
   localparam logic [2:0] ADDR_NEGFS = 3'h3;
   localparam logic [2:0] ADDR_DATA = 3'h4;
   // ------------------------------------------------------------
   // Control field positions
   // ------------------------------------------------------------
   localparam int MODE_LSB = 9;
   localparam int GAIN_LSB = 5;
   localparam int ORDER_BIT = 2;
   // ------------------------------------------------------------
   // Reset values and mode codes
   // ------------------------------------------------------------
   localparam logic [2:0] MODE_SELF_CAL = 3'h1;
   localparam logic [2:0] MODE_SYS_OFS = 3'h2;
   localparam logic [2:0] MODE_SYS_GAIN = 3'h3;
   localparam logic [2:0] MODE_SYS_OFS_SC = 3'h4;
   localparam logic [2:0] GAIN_UNITY = 3'h0;
   localparam logic [23:0] CTRL_RESET = 24'h000300;
   localparam logic [23:0] OFFSET_SELF_CAL = 24'h000000;
   localparam logic [23:0] POSFS_SELF_CAL = 24'h400000;
   localparam logic [23:0] NEGFS_SELF_CAL = 24'h400000;
   // ------------------------------------------------------------
   // Timing counts
   // ------------------------------------------------------------
   localparam int CAL_CYCLES = 64;
   localparam int CONV_CYCLES = 256;
endpackage

// file: rtl/adc_control_write_and_calibration_regs.sv
`timescale 1ns/10ps
module adc_control_write_and_calibration_regs
   import adc_cal_pkg::*;
#(
   parameter int CAL_LEN = CAL_CYCLES,
   parameter int CONV_LEN = CONV_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [2:0] regAddr,
   input wire logic [1:0] regByte,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic [23:0] rawWord,
   output logic result_valid_n,
   output logic [2:0] op_mode_field,
   output logic [2:0] gain_select_field,
   output logic byte_order_select,
   output logic calBusy
);
   // Counts beyond the 16-bit phase timer cannot be served
   if (CAL_LEN < 1 || CONV_LEN < 2 || CAL_LEN > 65535 || CONV_LEN > 65535)
      $error("counts out of range");

   typedef enum logic [1:0] {IDLE, CAL, CONV, READY} phase_t;

   logic [23:0] ctrl_q, ctrl_d; // Control register
   logic [23:0] offset_q, offset_d; // Offset coefficient
   logic [23:0] posfs_q, posfs_d; // Positive scale coefficient
   logic [23:0] negfs_q, negfs_d; // Negative scale coefficient
   logic [23:0] dout_q, dout_d; // Data output register
   phase_t phase_q, phase_d; // Sequencer phase
   logic [15:0] cnt_q, cnt_d; // Phase timer
   logic [7:0] rdByte; // Selected read byte
   logic [23:0] corrWord; // Corrected filter word
   logic corrValid; // Correction done strobe
   logic sampleEn; // End of conversion pulse
   logic restart; // Upper/middle control write
   logic calMode; // Mode selects a calibration
   logic [2:0] newMode; // Mode after this cycle's write
   logic [23:0] wmask; // Written byte lane as bit mask

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   // One byte lane per write; lane 2 is bits 23:16
   always_comb begin
      wmask = 24'h0000FF << (8 * regByte);
      ctrl_d = ctrl_q;
      offset_d = offset_q;
      posfs_d = posfs_q;
      negfs_d = negfs_q;
      if (regWrEn && regByte != 2'h3) begin
         case (regAddr)
            ADDR_CONTROL: ctrl_d = (ctrl_q & ~wmask) | ({3{regWrData}} & wmask);
            ADDR_OFFSET: offset_d = (offset_q & ~wmask) | ({3{regWrData}} & wmask);
            ADDR_POSFS: posfs_d = (posfs_q & ~wmask) | ({3{regWrData}} & wmask);
            ADDR_NEGFS: negfs_d = (negfs_q & ~wmask) | ({3{regWrData}} & wmask);
            default: ; // Data register and unmapped: write ignored
         endcase
      end
      // Only byte 2 or byte 1 of control restarts; byte 0 is quiet
      restart = regWrEn && regAddr == ADDR_CONTROL
         && (regByte == 2'h2 || regByte == 2'h1);
      newMode = ctrl_d[MODE_LSB+:3];
      calMode = newMode == MODE_SELF_CAL || newMode == MODE_SYS_OFS
         || newMode == MODE_SYS_GAIN || newMode == MODE_SYS_OFS_SC;
   end

   // ------------------------------------------------------------
   // Conversion and calibration sequencer
   // ------------------------------------------------------------
   // Calibration only runs the phase timer; the coefficient registers keep their values in this model
   always_comb begin
      phase_d = phase_q;
      cnt_d = cnt_q;
      dout_d = dout_q;
      sampleEn = 1'b0;
      case (phase_q)
         IDLE: begin
            phase_d = calMode ? CAL : CONV;
            cnt_d = '0;
         end
         CAL: begin
            if (cnt_q == 16'(CAL_LEN - 1)) begin
               phase_d = CONV;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         CONV, READY: begin
            if (cnt_q == 16'(CONV_LEN - 1)) begin
               sampleEn = 1'b1;
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
            // Completed read of the data register releases ready
            if (regRdEn && regAddr == ADDR_DATA && regByte == 2'h0 && phase_q == READY)
               phase_d = CONV;
            // Result is latched on the correction strobe, the cycle after the conversion pulse
            // A fresh result in the same cycle wins over the release
            if (corrValid) begin
               dout_d = corrWord;
               phase_d = READY;
            end
         end
         default: phase_d = IDLE;
      endcase
      // Control restart beats every other phase and timer update
      if (restart) begin
         phase_d = calMode ? CAL : CONV;
         cnt_d = '0;
      end
   end

   // State registers
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ctrl_q <= CTRL_RESET;
         offset_q <= OFFSET_SELF_CAL;
         posfs_q <= POSFS_SELF_CAL;
         negfs_q <= NEGFS_SELF_CAL;
         dout_q <= '0;
         phase_q <= IDLE;
         cnt_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         offset_q <= offset_d;
         posfs_q <= posfs_d;
         negfs_q <= negfs_d;
         dout_q <= dout_d;
         phase_q <= phase_d;
         cnt_q <= cnt_d;
      end
   end

   // ------------------------------------------------------------
   // Correction datapath
   // ------------------------------------------------------------
   cal_correct #(
      .W(24)
   ) u_correct (
      .core_clk(core_clk),
      .rstn(rstn),
      .sampleEn(sampleEn),
      .rawWord(rawWord),
      .offsetCoeff(offset_q),
      .posCoeff(posfs_q),
      .negCoeff(negfs_q),
      .corrWord(corrWord),
      .corrValid(corrValid)
   );

   // ------------------------------------------------------------
   // Read mux and outputs
   // ------------------------------------------------------------
   // Combinational read of the addressed byte lane
   always_comb begin
      if (regByte == 2'h3) begin
         rdByte = 8'h00; // Lane 3 does not exist
      end else begin
         case (regAddr)
            ADDR_CONTROL: rdByte = ctrl_q[8*regByte+:8];
            ADDR_OFFSET: rdByte = offset_q[8*regByte+:8];
            ADDR_POSFS: rdByte = posfs_q[8*regByte+:8];
            ADDR_NEGFS: rdByte = negfs_q[8*regByte+:8];
            ADDR_DATA: rdByte = dout_q[8*regByte+:8];
            default: rdByte = 8'h00;
         endcase
      end
   end

   assign regRdData = rdByte;
   assign result_valid_n = phase_q != READY;
   assign op_mode_field = ctrl_q[MODE_LSB+:3];
   assign gain_select_field = ctrl_q[GAIN_LSB+:3];
   assign byte_order_select = ctrl_q[ORDER_BIT];
   assign calBusy = phase_q == CAL;
endmodule

// file: rtl/cal_correct.sv
`timescale 1ns/10ps
// Applies offset and slope coefficients to a raw filter word.
module cal_correct
   import adc_cal_pkg::*;
#(
   parameter int W = 24
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sampleEn,
   input wire logic [W-1:0] rawWord,
   input wire logic [W-1:0] offsetCoeff,
   input wire logic [W-1:0] posCoeff,
   input wire logic [W-1:0] negCoeff,
   output logic [W-1:0] corrWord,
   output logic corrValid
);
   // The slope scaling below is fixed to a 24-bit word
   if (W != 24)
      $error("cal_correct supports 24 bit words only");

   logic [W-1:0] corr_q, corr_d; // Corrected word register
   logic valid_q, valid_d; // One-cycle result strobe
   logic signed [W:0] diff; // Offset-removed word
   logic signed [2*W+1:0] prod; // Slope product
   logic [W-1:0] slope; // Chosen slope by sign

   // ------------------------------------------------------------
   // Correction datapath
   // ------------------------------------------------------------
   // Input equal to the offset gives all zeros, whatever the slope
   always_comb begin
      diff = $signed({1'b0, rawWord}) - $signed({1'b0, offsetCoeff});
      slope = diff[W] ? negCoeff : posCoeff;
      prod = diff * $signed({1'b0, slope});
      // Slope of 0x400000 is unity; saturation is left out for area
      corr_d = sampleEn ? prod[2*W-3:W-2] : corr_q;
      valid_d = sampleEn;
   end

   // Result registers
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         corr_q <= '0;
         valid_q <= 1'b0;
      end else begin
         corr_q <= corr_d;
         valid_q <= valid_d;
      end
   end

   assign corrWord = corr_q;
   assign corrValid = valid_q;
endmodule

// file: sim/adc_cal_checker.sv
`timescale 1ns/10ps
module adc_cal_checker
   import adc_cal_pkg::*;
#(
   parameter int CAL_LEN = 4,
   parameter int CONV_LEN = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [2:0] regAddr,
   input wire logic [1:0] regByte,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic [23:0] rawWord,
   input wire logic result_valid_n,
   input wire logic [2:0] op_mode_field,
   input wire logic [2:0] gain_select_field,
   input wire logic byte_order_select,
   input wire logic calBusy
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Write decode; lowWr and coefWr pick their lanes here, the other properties pick theirs
   wire logic ctlWr = regWrEn && regAddr == ADDR_CONTROL;
   wire logic lowWr = ctlWr && regByte == 2'h0;
   wire logic coefWr = regWrEn && regAddr inside {[ADDR_OFFSET:ADDR_NEGFS]} && regByte != 2'h3;
   // Written field values, so that the history functions see whole signals
   wire logic [2:0] wrMode = regWrData[3:1];
   wire logic [2:0] wrGain = regWrData[7:5];
   wire logic wrOrder = regWrData[2];
   property p_hi; ctlWr && regByte inside {2'h1, 2'h2} |=> result_valid_n; endproperty
   a_hi: assert property (p_hi) else $error("ready not released");
   property p_cal; ctlWr && regByte == 2'h1 && wrMode inside {[3'h1:3'h4]} |=> calBusy;
   endproperty
   a_cal: assert property (p_cal) else $error("no recalibration");
   property p_low; lowWr && !result_valid_n && !calBusy |=> !result_valid_n && !calBusy;
   endproperty
   a_low: assert property (p_low) else $error("low byte write restarted");
   property p_mode; ctlWr && regByte == 2'h1 |=> op_mode_field == $past(wrMode);
   endproperty
   a_mode: assert property (p_mode) else $error("mode field wrong");
   property p_gain; lowWr |=> gain_select_field == $past(wrGain); endproperty
   a_gain: assert property (p_gain) else $error("gain field wrong");
   property p_ord; lowWr |=> byte_order_select == $past(wrOrder); endproperty
   a_ord: assert property (p_ord) else $error("order bit wrong");
   // Host leaves one idle edge between accesses, so the read lands two edges on
   property p_coef; coefWr ##2 (regRdEn && regAddr == $past(regAddr, 2)
      && regByte == $past(regByte, 2)) |-> regRdData == $past(regWrData, 2); endproperty
   a_coef: assert property (p_coef) else $error("coefficient byte lost");
   // A result follows a whole conversion, so calibration ended well before
   property p_rdy; $fell(result_valid_n) |-> !calBusy && !$past(calBusy, 8); endproperty
   a_rdy: assert property (p_rdy) else $error("ready too soon after calibration");
endmodule
bind adc_control_write_and_calibration_regs adc_cal_checker #(.CAL_LEN(CAL_LEN),
   .CONV_LEN(CONV_LEN)) chk (.core_clk, .rstn, .regWrEn, .regRdEn, .regAddr, .regByte,
   .regWrData, .regRdData, .rawWord, .result_valid_n, .op_mode_field,
   .gain_select_field, .byte_order_select, .calBusy);

// file: sim/adc_control_write_and_calibration_regs_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin nTests++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module adc_control_write_and_calibration_regs_bench;
   import adc_cal_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [23:0] rawWord = 24'h123456;
   logic regWrEn, regRdEn, byte_order_select, calBusy, result_valid_n;
   logic [2:0] regAddr, op_mode_field, gain_select_field;
   logic [1:0] regByte;
   logic [7:0] regWrData, regRdData, d;
   logic [23:0] rv [4] = '{CTRL_RESET, OFFSET_SELF_CAL, POSFS_SELF_CAL, NEGFS_SELF_CAL};
   int miscompares = 0;
   int nTests = 0;
   logic [23:0] word; // Data word read back
   always #4 core_clk = ~core_clk;
   adc_control_write_and_calibration_regs #(.CAL_LEN(4), .CONV_LEN(8)) dut (.core_clk,
      .rstn, .regWrEn, .regRdEn, .regAddr, .regByte, .regWrData, .regRdData, .rawWord,
      .result_valid_n, .op_mode_field, .gain_select_field, .byte_order_select, .calBusy);
   host_model host (.core_clk, .regRdData, .regWrEn, .regRdEn, .regAddr, .regByte,
      .regWrData);
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Bounded wait for a fresh result
   task automatic waitReady();
      int i;
      i = 0;
      while (result_valid_n !== 1'b0 && i < 200) begin
         @(posedge core_clk);
         i++;
      end
      `CHK("ready wait", 1'b0, result_valid_n)
      if (i == 200) end_of_test();
   endtask
   // Data word, top lane first; the low lane read completes it
   task automatic readWord(output logic [23:0] w);
      for (int b = 2; b >= 0; b--) begin
         host.rd(ADDR_DATA, b[1:0], d);
         w[8*b +: 8] = d;
      end
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      for (int a = 0; a < 4; a++) for (int b = 0; b < 3; b++) begin
         host.rd(a[2:0], b[1:0], d);
         `CHK("reset byte", rv[a][8*b +: 8], d)
      end
      `CHK("reset mode", MODE_SELF_CAL, op_mode_field)
      $display("test reset done");
      for (int a = 1; a < 4; a++) for (int b = 0; b < 3; b++) begin
         host.wr(a[2:0], b[1:0], {2'h2, a[2:0], b[2:0]});
         host.rd(a[2:0], b[1:0], d);
         `CHK("coef byte", {2'h2, a[2:0], b[2:0]}, d)
      end
      host.rd(ADDR_OFFSET, 2'h3, d);
      `CHK("lane 3", 8'h00, d)
      $display("test coefficients done");
      waitReady();
      host.wr(ADDR_CONTROL, 2'h0, 8'hA4);
      #1;
      `CHK("low write ready", 1'b0, result_valid_n)
      `CHK("low write busy", 1'b0, calBusy)
      `CHK("gain", 3'h5, gain_select_field)
      `CHK("order", 1'b1, byte_order_select)
      for (int m = 0; m < 5; m++) begin
         waitReady();
         host.wr(ADDR_CONTROL, 2'h1, {4'h0, m[2:0], 1'b1});
         #1;
         `CHK("ready high", 1'b1, result_valid_n)
         `CHK("recal", m > 0, calBusy)
         `CHK("mode", m[2:0], op_mode_field)
      end
      $display("test control writes done");
      for (int b = 0; b < 3; b++) host.wr(ADDR_OFFSET, b[1:0], rawWord[8*b +: 8]);
      host.ctlAll(24'h000100);
      waitReady();
      for (int b = 2; b >= 0; b--) begin
         host.rd(ADDR_DATA, b[1:0], d);
         `CHK("zero input word", 8'h00, d)
      end
      #1;
      `CHK("ready after read", 1'b1, result_valid_n)
      $display("test offset done");
      // No offset, positive slope at twice the unity code doubles the word
      host.regAll(ADDR_OFFSET, 24'h000000);
      host.regAll(ADDR_POSFS, 24'h800000);
      host.ctlAll(24'h000100);
      waitReady();
      readWord(word);
      `CHK("positive slope word", 24'h2468AC, word)
      // Input below the offset takes the negative slope, here at unity
      host.regAll(ADDR_NEGFS, 24'h400000);
      host.regAll(ADDR_OFFSET, 24'h200000);
      host.ctlAll(24'h000100);
      waitReady();
      readWord(word);
      `CHK("negative slope word", 24'hF23456, word)
      $display("test slopes done");
      end_of_test();
   end
endmodule

// file: sim/host_model.sv
`timescale 1ns/10ps
module host_model
   import adc_cal_pkg::*;
(
   input wire logic core_clk,
   input wire logic [7:0] regRdData,
   output logic regWrEn = 1'b0,
   output logic regRdEn = 1'b0,
   output logic [2:0] regAddr = 3'h7,
   output logic [1:0] regByte = 2'h3,
   output logic [7:0] regWrData = 8'hA5
);
   // One strobed byte write; idle data flips so stale bytes never match
   task automatic wr(input logic [2:0] a, input logic [1:0] b, input logic [7:0] d);
      @(posedge core_clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regByte <= b;
      regWrData <= d;
      @(posedge core_clk);
      regWrEn <= 1'b0;
      regWrData <= ~d;
   endtask
   // One byte read, data taken at the strobe's sampling edge
   task automatic rd(input logic [2:0] a, input logic [1:0] b, output logic [7:0] d);
      @(posedge core_clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      regByte <= b;
      @(posedge core_clk);
      d = regRdData;
      regRdEn <= 1'b0;
   endtask
   // All three lanes of one register, top lane first
   task automatic regAll(input logic [2:0] a, input logic [23:0] v);
      for (int b = 2; b >= 0; b--) wr(a, b[1:0], v[8*b +: 8]);
   endtask
   // Whole control word, so a gain change always comes after a restart
   task automatic ctlAll(input logic [23:0] v);
      regAll(ADDR_CONTROL, v);
   endtask
endmodule
